// *** verilog/prcd_top.sv ***
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
// Function
// - Platform code 4..9 gives ratio 4..9:1, other codes reserved.
// - Cluster code 8..18 gives ratio 8..18:1, other codes reserved.
// - Two independent cluster PLLs, each from its own ratio field.
// - Bank 1 ratio: 010=25, 011=40, 100=50, rest reserved.
// - Bank 2 ratio: 001=20,010=25,011=40,100=50,101=24,110=30.
// - Bank 1 divider: five bits, one per lane pair, 1 divides by two.
// - Bank 2 divider: one bit for all four lanes, 1 divides by two.
// - Frame unit clock: 0 half platform, 1 half cluster 2.
// - Each set lane power-down bit powers down its lane.
// - Block enable 0 powers down serial block and both bank PLLs.
// - Software writing power-down bit 1 stops that bank PLL.
module prcd_top
   import prcd_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic resetn, // Power-up reset
   input wire logic [4:0] platform_multiplier_field, // Platform ratio code
   input wire logic [1:0] platform_pll_range_select, // Platform range
   input wire logic [4:0] cluster1_multiplier_field, // Cluster 1 ratio code
   input wire logic [4:0] cluster2_multiplier_field, // Cluster 2 ratio code
   input wire logic [1:0] cluster1_pll_range_select, // Cluster 1 range
   input wire logic [1:0] cluster2_pll_range_select, // Cluster 2 range
   input wire logic [2:0] serial_bank1_ratio_field, // Bank 1 ratio code
   input wire logic [2:0] serial_bank2_ratio_field, // Bank 2 ratio code
   input wire logic [4:0] bank1_lane_pair_divider, // Bank 1 pair dividers
   input wire logic bank2_lane_divider, // Bank 2 divider
   input wire logic frame_unit_clock_select, // Frame unit source
   input wire logic serial_block_enable, // Serial block enable
   input wire logic [9:0] bank1_lane_power_down_field, // Bank 1 lane pd
   input wire logic [3:0] bank2_lane_power_down_field, // Bank 2 lane pd
   input wire logic hsel, // AHB select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response
   output logic [31:0] hrdata, // AHB read data
   output logic config_captured, // Fields captured
   output logic [3:0] platform_ratio, // Platform ratio, 0 reserved
   output logic platform_pll_enable, // Platform PLL on
   output logic [1:0] platform_range, // Platform range setting
   output logic [4:0] cluster1_ratio, // Cluster 1 ratio
   output logic [4:0] cluster2_ratio, // Cluster 2 ratio
   output logic cluster1_pll_enable, // Cluster 1 PLL on
   output logic cluster2_pll_enable, // Cluster 2 PLL on
   output logic [1:0] cluster1_range, // Cluster 1 range setting
   output logic [1:0] cluster2_range, // Cluster 2 range setting
   output logic [5:0] bank1_ratio, // Bank 1 PLL ratio
   output logic [5:0] bank2_ratio, // Bank 2 PLL ratio
   output logic bank1_pll_enable, // Bank 1 PLL on
   output logic bank2_pll_enable, // Bank 2 PLL on
   output logic [4:0] bank1_pair_div2, // Bank 1 pair divide by two
   output logic bank2_div2, // Bank 2 divide by two
   output logic frame_clock_from_cluster2, // Frame unit source
   output logic serial_block_power_down, // Serial block off
   output logic [9:0] bank1_lane_power_down, // Bank 1 lanes off
   output logic [3:0] bank2_lane_power_down, // Bank 2 lanes off
   output logic config_error // Reserved code seen
);

   // ****************************************************************
   // Configuration capture
   // ****************************************************************
   logic [CFG_W-1:0] cfg_in;
   logic [CFG_W-1:0] cfg_meta_r;
   logic [CFG_W-1:0] cfg_sync_r;
   logic [CFG_W-1:0] capt_r;
   logic [CFG_W-1:0] capt_nxt;
   logic [2:0] settle_r;
   logic [2:0] settle_nxt;
   prcd_cap_type cap_r;
   prcd_cap_type cap_nxt;

   // Bit order matches the capture readback
   assign cfg_in = {bank2_lane_power_down_field, bank1_lane_power_down_field,
                    serial_block_enable, frame_unit_clock_select, bank2_lane_divider,
                    bank1_lane_pair_divider, serial_bank2_ratio_field,
                    serial_bank1_ratio_field, cluster2_pll_range_select,
                    cluster1_pll_range_select, cluster2_multiplier_field,
                    cluster1_multiplier_field, platform_pll_range_select,
                    platform_multiplier_field};

   // Config pins are asynchronous, two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_meta_r <= '0;
         cfg_sync_r <= '0;
      end else begin
         cfg_meta_r <= cfg_in;
         cfg_sync_r <= cfg_meta_r;
      end
   end

   always_comb begin
      cap_nxt = cap_r;
      settle_nxt = settle_r;
      capt_nxt = capt_r;
      case (cap_r)
         CAP_SETTLE: begin
            if (settle_r == SETTLE_CYCLES) begin
               capt_nxt = cfg_sync_r;
               cap_nxt = CAP_HOLD;
            end else begin
               settle_nxt = settle_r + 3'h1;
            end
         end
         CAP_HOLD: cap_nxt = CAP_HOLD;
         default: cap_nxt = CAP_SETTLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cap_r <= CAP_SETTLE;
         settle_r <= 3'h0;
         capt_r <= '0;
      end else begin
         cap_r <= cap_nxt;
         settle_r <= settle_nxt;
         capt_r <= capt_nxt;
      end
   end

   // Capture done, fields frozen until reset
   wire held = (cap_r == CAP_HOLD);
   wire blk_en = held && capt_r[SBE_LSB];

   // ****************************************************************
   // Ratio decode
   // ****************************************************************
   wire [4:0] pmf = capt_r[PMF_LSB +: PMF_W];
   wire plat_ok = (pmf >= PLAT_MIN) && (pmf <= PLAT_MAX);
   wire [3:0] plat_ratio = plat_ok ? pmf[3:0] : 4'h0;

   logic [1:0] clus_ok;
   logic [1:0][4:0] clus_ratio;
   logic [1:0][1:0] clus_range;
   logic [1:0] bank_ok;
   logic [1:0][5:0] bank_rat;
   logic [1:0] bank_pd_r;
   logic [1:0] bank_pll_on;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pll
         wire [4:0] cmf = capt_r[CMF_LSB + gi*PMF_W +: PMF_W];
         assign clus_ok[gi] = (cmf >= CLUS_MIN) && (cmf <= CLUS_MAX);
         assign clus_ratio[gi] = clus_ok[gi] ? cmf : 5'h00;
         assign clus_range[gi] = capt_r[CRS_LSB + gi*RS_W +: RS_W];
         assign bank_rat[gi] = prcd_bank_ratio(gi == 1, capt_r[SBR_LSB + gi*SBR_W +: SBR_W]);
         assign bank_ok[gi] = (bank_rat[gi] != 6'h00);
         assign bank_pll_on[gi] = blk_en && bank_ok[gi] && !bank_pd_r[gi];
      end
   endgenerate

   wire err_any = held && !(plat_ok && (&clus_ok) && (&bank_ok));

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_nxt;
   logic hreadyout_r;
   logic hresp_r;
   logic [31:0] hrdata_r;

   // Zero wait states, one word per transfer
   wire take = hsel && hready && htrans[1];
   wire [7:0] a_off = haddr[7:0];
   wire wr_b1 = wr_pend_r && (wr_addr_r == BANK1_CTL_OFF);
   wire wr_b2 = wr_pend_r && (wr_addr_r == BANK2_CTL_OFF);
   // Forward pending write to a read just behind it
   wire pd1_now = wr_b1 ? hwdata[PD_BIT] : bank_pd_r[0];
   wire pd2_now = wr_b2 ? hwdata[PD_BIT] : bank_pd_r[1];
   // Status: error, bank, cluster, platform, captured
   wire [6:0] stat = {err_any, ~bank_ok, ~clus_ok, ~plat_ok & held, held};

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (a_off)
         BANK1_CTL_OFF: rdata_nxt = {31'h0, pd1_now};
         BANK2_CTL_OFF: rdata_nxt = {31'h0, pd2_now};
         STATUS_OFF: rdata_nxt = {25'h0, stat};
         CAPT_LO_OFF: rdata_nxt = capt_r[31:0];
         CAPT_HI_OFF: rdata_nxt = {15'h0, capt_r[CFG_W-1:32]};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Write lands at the end of its data phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         if (hready) begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= a_off;
         end
         if (take && !hwrite) begin
            hrdata_r <= rdata_nxt;
         end
      end
   end

   // Level bit, writing zero wakes the bank
   // software bank power-down
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bank_pd_r <= {BANK_PD_RST, BANK_PD_RST};
      end else begin
         bank_pd_r <= {pd2_now, pd1_now};
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************
   // Reset leaves every PLL and lane off
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         config_captured <= 1'b0;
         platform_ratio <= 4'h0;
         platform_pll_enable <= 1'b0;
         platform_range <= 2'h0;
         cluster1_ratio <= 5'h00;
         cluster2_ratio <= 5'h00;
         cluster1_pll_enable <= 1'b0;
         cluster2_pll_enable <= 1'b0;
         cluster1_range <= 2'h0;
         cluster2_range <= 2'h0;
         bank1_ratio <= 6'h00;
         bank2_ratio <= 6'h00;
         bank1_pll_enable <= 1'b0;
         bank2_pll_enable <= 1'b0;
         bank1_pair_div2 <= 5'h00;
         bank2_div2 <= 1'b0;
         frame_clock_from_cluster2 <= 1'b0;
         serial_block_power_down <= 1'b1;
         bank1_lane_power_down <= 10'h3FF;
         bank2_lane_power_down <= 4'hF;
         config_error <= 1'b0;
      end else begin
         config_captured <= held;
         platform_ratio <= plat_ratio;
         platform_pll_enable <= held && plat_ok;
         platform_range <= capt_r[PRS_LSB +: RS_W];
         cluster1_ratio <= clus_ratio[0];
         cluster2_ratio <= clus_ratio[1];
         cluster1_pll_enable <= held && clus_ok[0];
         cluster2_pll_enable <= held && clus_ok[1];
         cluster1_range <= clus_range[0];
         cluster2_range <= clus_range[1];
         bank1_ratio <= bank_rat[0];
         bank2_ratio <= bank_rat[1];
         bank1_pll_enable <= bank_pll_on[0];
         bank2_pll_enable <= bank_pll_on[1];
         bank1_pair_div2 <= capt_r[B1DIV_LSB +: B1DIV_W];
         bank2_div2 <= capt_r[B2DIV_LSB];
         frame_clock_from_cluster2 <= capt_r[FCS_LSB];
         serial_block_power_down <= !blk_en;
         bank1_lane_power_down <= capt_r[LPD1_LSB +: LPD1_W] | {LPD1_W{!blk_en}};
         bank2_lane_power_down <= capt_r[LPD2_LSB +: LPD2_W] | {LPD2_W{!blk_en}};
         config_error <= err_any;
      end
   end

   // Bus outputs straight from flops
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;

endmodule // prcd_top

// *** pkg/prcd_pkg.sv ***
package prcd_pkg;

   // ****************************************************************
   // Configuration word layout
   // ****************************************************************
   localparam int CFG_W = 49;
   localparam int PMF_LSB = 0;
   localparam int PMF_W = 5;
   localparam int PRS_LSB = 5;
   localparam int RS_W = 2;
   localparam int CMF_LSB = 7;
   localparam int CRS_LSB = 17;
   localparam int SBR_LSB = 21;
   localparam int SBR_W = 3;
   localparam int B1DIV_LSB = 27;
   localparam int B1DIV_W = 5;
   localparam int B2DIV_LSB = 32;
   localparam int FCS_LSB = 33;
   localparam int SBE_LSB = 34;
   localparam int LPD1_LSB = 35;
   localparam int LPD1_W = 10;
   localparam int LPD2_LSB = 45;
   localparam int LPD2_W = 4;

   // ****************************************************************
   // Ratio code limits
   // ****************************************************************
   localparam logic [4:0] PLAT_MIN = 5'h04;
   localparam logic [4:0] PLAT_MAX = 5'h09;
   localparam logic [4:0] CLUS_MIN = 5'h08;
   localparam logic [4:0] CLUS_MAX = 5'h12;
   localparam int BANK_RAT_W = 6;

   // ****************************************************************
   // Register offsets and reset values
   // ****************************************************************
   localparam logic [7:0] BANK1_CTL_OFF = 8'h00;
   localparam logic [7:0] BANK2_CTL_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] CAPT_LO_OFF = 8'h0C;
   localparam logic [7:0] CAPT_HI_OFF = 8'h10;
   localparam int PD_BIT = 0;
   localparam logic BANK_PD_RST = 1'b0;
   localparam logic [2:0] SETTLE_CYCLES = 3'h3;

   typedef enum {CAP_SETTLE, CAP_HOLD} prcd_cap_type;

   // Bank PLL ratio, zero for reserved codes
   function automatic logic [5:0] prcd_bank_ratio(input logic bank2, input logic [2:0] code);
      logic [5:0] r;
      r = 6'h00;
      case (code)
         3'h1: r = bank2 ? 6'h14 : 6'h00;
         3'h2: r = 6'h19;
         3'h3: r = 6'h28;
         3'h4: r = 6'h32;
         3'h5: r = bank2 ? 6'h18 : 6'h00;
         3'h6: r = bank2 ? 6'h1E : 6'h00;
         default: r = 6'h00;
      endcase
      return r;
   endfunction

endpackage

// *** bench/prcd_monitor.sv ***
`timescale 1ns/10ps
module prcd_monitor (
   input wire logic ref_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer
   input wire logic hwrite, // Write
   input wire logic [31:0] hwdata, // Write data
   input wire logic config_captured, // Captured
   input wire logic [3:0] platform_ratio, // Platform
   input wire logic platform_pll_enable, // Platform on
   input wire logic [4:0] cluster1_ratio, // Cluster 1
   input wire logic [4:0] cluster2_ratio, // Cluster 2
   input wire logic cluster1_pll_enable, // Cluster 1 on
   input wire logic cluster2_pll_enable, // Cluster 2 on
   input wire logic [5:0] bank1_ratio, // Bank 1
   input wire logic [5:0] bank2_ratio, // Bank 2
   input wire logic bank1_pll_enable, // Bank 1 on
   input wire logic bank2_pll_enable, // Bank 2 on
   input wire logic serial_block_power_down, // Block off
   input wire logic [9:0] bank1_lane_power_down, // Bank 1 lanes
   input wire logic [3:0] bank2_lane_power_down, // Bank 2 lanes
   input wire logic config_error // Error
);
   // ****
   // Decode checks
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_plat_ratio_set: assert property (config_captured |-> platform_ratio inside {0, [4:9]}
      && platform_pll_enable == (platform_ratio != 0)) else $error("platform ratio bad");
   a_clus_ratio_set: assert property (config_captured |-> cluster1_ratio inside {0, [8:18]}
      && cluster1_pll_enable == (cluster1_ratio != 0)) else $error("cluster 1 ratio bad");
   a_clus_two_set: assert property (config_captured |-> cluster2_ratio inside {0, [8:18]}
      && cluster2_pll_enable == (cluster2_ratio != 0)) else $error("cluster 2 ratio bad");
   a_bank_ratio_set: assert property (bank1_ratio inside {0, 25, 40, 50}
      && bank2_ratio inside {0, 20, 24, 25, 30, 40, 50}) else $error("bank ratio bad");
   a_block_off_pd: assert property (serial_block_power_down |-> !bank1_pll_enable
      && !bank2_pll_enable && &bank1_lane_power_down && &bank2_lane_power_down)
      else $error("block off not honoured");
   a_fields_held: assert property (config_captured && $past(config_captured) |->
      $stable(platform_ratio) && $stable(cluster1_ratio) && $stable(cluster2_ratio)
      && $stable(bank1_ratio) && $stable(bank2_ratio)) else $error("fields changed");
   a_error_flag: assert property (config_captured |-> config_error == (platform_ratio == 0
      || cluster1_ratio == 0 || cluster2_ratio == 0 || bank1_ratio == 0 || bank2_ratio == 0))
      else $error("error flag wrong");
   a_bank1_sw_pd: assert property ((hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00
      ##1 hwdata[0]) |-> ##[1:2] !bank1_pll_enable) else $error("bank 1 pll not off");
   a_bank2_sw_pd: assert property ((hsel && htrans[1] && hwrite && haddr[7:0] == 8'h04
      ##1 hwdata[0]) |-> ##[1:2] !bank2_pll_enable) else $error("bank 2 pll not off");
endmodule // prcd_monitor
bind prcd_top prcd_monitor mon (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .config_captured, .platform_ratio, .platform_pll_enable, .cluster1_ratio, .cluster2_ratio,
   .cluster1_pll_enable, .cluster2_pll_enable, .bank1_ratio, .bank2_ratio, .bank1_pll_enable,
   .bank2_pll_enable, .serial_block_power_down, .bank1_lane_power_down,
   .bank2_lane_power_down, .config_error);

// *** bench/prcd_cfg_source.sv ***
`timescale 1ns/10ps
module prcd_cfg_source (
   input wire logic [48:0] word, // Raw configuration word
   output logic [4:0] platform_multiplier_field, // Platform code
   output logic [1:0] platform_pll_range_select, // Platform range
   output logic [4:0] cluster1_multiplier_field, // Cluster 1 code
   output logic [4:0] cluster2_multiplier_field, // Cluster 2 code
   output logic [1:0] cluster1_pll_range_select, // Cluster 1 range
   output logic [1:0] cluster2_pll_range_select, // Cluster 2 range
   output logic [2:0] serial_bank1_ratio_field, // Bank 1 code
   output logic [2:0] serial_bank2_ratio_field, // Bank 2 code
   output logic [4:0] bank1_lane_pair_divider, // Pair dividers
   output logic bank2_lane_divider, // Bank 2 divider
   output logic frame_unit_clock_select, // Frame source
   output logic serial_block_enable, // Block enable
   output logic [9:0] bank1_lane_power_down_field, // Bank 1 lanes
   output logic [3:0] bank2_lane_power_down_field // Bank 2 lanes
);
   // ****
   // Field split
   // ****
   assign platform_multiplier_field = word[4:0];
   assign platform_pll_range_select = 2'h1;
   assign cluster1_multiplier_field = word[11:7];
   assign cluster2_multiplier_field = word[16:12];
   assign cluster1_pll_range_select = (word[11:7] >= 5'h0F) ? 2'h0 : 2'h1;
   assign cluster2_pll_range_select = (word[16:12] >= 5'h0F) ? 2'h0 : 2'h1;
   assign serial_bank1_ratio_field = word[23:21];
   assign serial_bank2_ratio_field = word[26:24];
   assign bank1_lane_pair_divider = word[31:27];
   assign bank2_lane_divider = word[32];
   assign frame_unit_clock_select = word[33];
   assign serial_block_enable = word[34];
   assign bank1_lane_power_down_field = word[34] ? word[44:35] : 10'h3FF;
   assign bank2_lane_power_down_field = word[34] ? word[48:45] : 4'hF;
endmodule // prcd_cfg_source

// *** bench/prcd_top_test.sv ***
`timescale 1ns/10ps
module prcd_top_test;
   import prcd_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h274E, rd;
   logic [48:0] word = 49'h0, w;
   int fail_count = 0, checks_done = 0;
   wire logic hreadyout, hresp, config_captured, platform_pll_enable, cluster1_pll_enable;
   wire logic cluster2_pll_enable, bank1_pll_enable, bank2_pll_enable, bank2_div2;
   wire logic frame_clock_from_cluster2, serial_block_power_down, config_error;
   wire logic bank2_lane_divider, frame_unit_clock_select, serial_block_enable;
   wire logic [31:0] hrdata;
   wire logic [1:0] platform_range, cluster1_range, cluster2_range, platform_pll_range_select;
   wire logic [1:0] cluster1_pll_range_select, cluster2_pll_range_select;
   wire logic [3:0] platform_ratio, bank2_lane_power_down, bank2_lane_power_down_field;
   wire logic [4:0] cluster1_ratio, cluster2_ratio, bank1_pair_div2, platform_multiplier_field;
   wire logic [4:0] cluster1_multiplier_field, cluster2_multiplier_field, bank1_lane_pair_divider;
   wire logic [5:0] bank1_ratio, bank2_ratio;
   wire logic [2:0] serial_bank1_ratio_field, serial_bank2_ratio_field;
   wire logic [9:0] bank1_lane_power_down, bank1_lane_power_down_field;
   prcd_cfg_source src (.word, .platform_multiplier_field, .platform_pll_range_select,
      .cluster1_multiplier_field, .cluster2_multiplier_field, .cluster1_pll_range_select,
      .cluster2_pll_range_select, .serial_bank1_ratio_field, .serial_bank2_ratio_field,
      .bank1_lane_pair_divider, .bank2_lane_divider, .frame_unit_clock_select,
      .serial_block_enable, .bank1_lane_power_down_field, .bank2_lane_power_down_field);
   prcd_top dut (.ref_clk, .resetn, .platform_multiplier_field, .platform_pll_range_select,
      .cluster1_multiplier_field, .cluster2_multiplier_field, .cluster1_pll_range_select,
      .cluster2_pll_range_select, .serial_bank1_ratio_field, .serial_bank2_ratio_field,
      .bank1_lane_pair_divider, .bank2_lane_divider, .frame_unit_clock_select,
      .serial_block_enable, .bank1_lane_power_down_field, .bank2_lane_power_down_field, .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .config_captured, .platform_ratio, .platform_pll_enable, .platform_range,
      .cluster1_ratio, .cluster2_ratio, .cluster1_pll_enable, .cluster2_pll_enable,
      .cluster1_range, .cluster2_range, .bank1_ratio, .bank2_ratio, .bank1_pll_enable,
      .bank2_pll_enable, .bank1_pair_div2, .bank2_div2, .frame_clock_from_cluster2,
      .serial_block_power_down, .bank1_lane_power_down, .bank2_lane_power_down, .config_error);
   // ****
   // Expectation and bus helpers
   // ****
   initial forever #4 ref_clk = ~ref_clk;
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
   endfunction
   function automatic logic pok(input logic [4:0] c);
      return c >= 5'h04 && c <= 5'h09;
   endfunction
   function automatic logic cok(input logic [4:0] c);
      return c >= 5'h08 && c <= 5'h12;
   endfunction
   function automatic logic [5:0] bexp(input logic b2, input logic [2:0] c);
      case (c)
         3'h1: return b2 ? 6'h14 : 6'h00;
         3'h2: return 6'h19;
         3'h3: return 6'h28;
         3'h4: return 6'h32;
         3'h5: return b2 ? 6'h18 : 6'h00;
         3'h6: return b2 ? 6'h1E : 6'h00;
         default: return 6'h00;
      endcase
   endfunction
   function automatic logic eexp(input logic [48:0] x);
      return !pok(x[4:0]) || !cok(x[11:7]) || !cok(x[16:12]) || bexp(0, x[23:21]) == 0
         || bexp(1, x[26:24]) == 0;
   endfunction
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wt;
      int n;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin fail_count++; complete_run(); end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
      wt();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wt();
      rd = hrdata;
   endtask
   task automatic check(input logic p1, input logic p2);
      logic en;
      en = w[34];
      @(negedge ref_clk);
      chk(platform_ratio, pok(w[4:0]) ? w[3:0] : 4'h0);
      chk(platform_pll_enable, pok(w[4:0]));
      chk(cluster1_ratio, cok(w[11:7]) ? w[11:7] : 5'h00);
      chk(cluster2_ratio, cok(w[16:12]) ? w[16:12] : 5'h00);
      chk({cluster2_pll_enable, cluster1_pll_enable}, {cok(w[16:12]), cok(w[11:7])});
      chk(bank1_ratio, bexp(0, w[23:21]));
      chk(bank2_ratio, bexp(1, w[26:24]));
      chk(bank1_pll_enable, en && bexp(0, w[23:21]) != 0 && !p1);
      chk(bank2_pll_enable, en && bexp(1, w[26:24]) != 0 && !p2);
      chk(bank1_pair_div2, w[31:27]);
      chk(bank2_div2, w[32]);
      chk(frame_clock_from_cluster2, w[33]);
      chk(bank1_lane_power_down, en ? w[44:35] : 10'h3FF);
      chk(bank2_lane_power_down, en ? w[48:45] : 4'hF);
      chk(serial_block_power_down, !en);
      chk(config_error, eexp(w));
      chk(platform_range, 2'h1);
      chk(cluster1_range, (w[11:7] >= 5'h0F) ? 2'h0 : 2'h1);
      chk(cluster2_range, (w[16:12] >= 5'h0F) ? 2'h0 : 2'h1);
      chk(hresp, 1'b0);
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      for (int r = 0; r < 8; r++) begin
         seed = nxt(seed);
         w[31:0] = seed;
         seed = nxt(seed);
         w[48:32] = seed[16:0];
         if (r == 0) begin
            w[4:0] = 5'h09; w[11:7] = 5'h08; w[16:12] = 5'h12; w[26:21] = 6'h0C; w[34] = 1'b1;
         end else if (r == 1) begin
            w[4:0] = 5'h0A; w[11:7] = 5'h07; w[16:12] = 5'h13; w[26:21] = 6'h39; w[34] = 1'b0;
         end
         @(posedge ref_clk);
         resetn <= 1'b0;
         word <= w;
         repeat (4) @(posedge ref_clk);
         resetn <= 1'b1;
         for (int n = 0; n < 20 && config_captured !== 1'b1; n++) @(negedge ref_clk);
         if (config_captured !== 1'b1) begin fail_count++; complete_run(); end
         check(1'b0, 1'b0);
         for (int b = 0; b < 2; b++) begin
            ahb(1'b1, 8'(b * 4), 32'h1);
            repeat (2) @(negedge ref_clk);
            check(b == 0, b == 1);
            ahb(1'b0, 8'(b * 4), 32'h0);
            chk(rd, 32'h1);
            ahb(1'b1, 8'(b * 4), 32'h0);
         end
         ahb(1'b0, 8'h08, 32'h0);
         chk(rd, {25'h0, eexp(w), bexp(1, w[26:24]) == 0, bexp(0, w[23:21]) == 0,
            !cok(w[16:12]), !cok(w[11:7]), !pok(w[4:0]), 1'b1});
         ahb(1'b0, 8'h20, 32'h0);
         chk(rd, 32'h0);
         ahb(1'b0, 8'h10, 32'h0);
         chk(rd, {15'h0, (w[34] ? w[48:35] : 14'h3FFF), w[34:32]});
         @(posedge ref_clk);
         word <= ~w;
         repeat (6) @(negedge ref_clk);
         check(1'b0, 1'b0);
      end
      complete_run();
   end
endmodule // prcd_top_test
